// file: src/aiseq_pkg.sv
/*
 * Constants for the analog-input acquisition sequencer: register offsets,
 * control and command bit positions, reset values and buffer shape.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
`default_nettype none

package aiseq_pkg;
    // ========================================================
    // Buffer shape
    localparam int SAMPLE_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W = 5;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    localparam logic [7:0] OFS_DONE_CNT = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_DIVIDER = 8'h18;
    localparam logic [7:0] OFS_BLOCK = 8'h1c;

    // ========================================================
    // Control register bits
    localparam int CTRL_HW_TIMED = 0;
    localparam int CTRL_EXT_CLK = 1;
    localparam int CTRL_CONTINUOUS = 2;
    localparam int CTRL_BUFFERED = 3;
    localparam int CTRL_IRQ_XFER = 4;
    localparam int CTRL_START_EN = 5;
    localparam int CTRL_REF_EN = 6;
    localparam int CTRL_PAUSE_EN = 7;
    localparam int CTRL_W = 8;

    // Command register bits
    localparam int CMD_CONVERT = 0;
    localparam int CMD_START = 1;
    localparam int CMD_STOP = 2;
    localparam int CMD_CLR_OVF = 3;

    // Status register bits
    localparam int ST_RUNNING = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_OVERFLOW = 2;
    localparam int ST_DONE = 3;
    localparam int ST_CFG_ERR = 4;
    localparam int ST_BUSY = 5;
    localparam int ST_LEVEL_LSB = 8;

    // ========================================================
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [31:0] COUNT_RST = 32'h0000_0001;
    localparam logic [15:0] DIVIDER_RST = 16'h0027;
    localparam logic [LEVEL_W-1:0] BLOCK_RST = 5'h08;

    // Acquisition phases
    typedef enum logic [1:0] {
        AISEQ_IDLE,
        AISEQ_WAIT_START,
        AISEQ_RUN
    } aiseq_state_type;
endpackage

`default_nettype wire

// file: src/aiseq_top.sv
/*
 * Analog-input acquisition sequencer: APB register slave, on-demand and
 * paced conversion control, trigger handling, sample FIFO with overwrite
 * on overflow, and a block drain port toward DMA or interrupt service.
 * Assumes every input is synchronous to mclk_in and the converter answers
 * each start pulse with exactly one done pulse carrying its result.
 */
`default_nettype none

// ============================================================
// Sample FIFO
module aiseq_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic                     clk_in,
    input  wire logic                     rstn_in,
    input  wire logic                     in_valid_in,
    output logic                          in_ready_out,
    input  wire logic [WIDTH-1:0]         in_data_in,
    output logic                          out_valid_out,
    input  wire logic                     out_ready_in,
    output logic [WIDTH-1:0]              out_data_out,
    output logic [$clog2(DEPTH):0]        level_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              do_pop  = out_ready_in && (cnt_q != '0);
    wire              full    = (cnt_q == (AW+1)'(DEPTH));
    wire              do_push = in_valid_in && (!full || do_pop);

    assign in_ready_out  = !full;
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
    assign level_out     = cnt_q;

    // Storage has no reset; pointers and count do
    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // Pointer and occupancy bookkeeping
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) wr_q <= wr_q + 1'b1;
            if (do_pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

// ============================================================
// Sequencer top
module aiseq_top (
    input  wire logic                          mclk_in,
    input  wire logic                          rstn_in,
    input  wire logic                          psel_in,
    input  wire logic                          penable_in,
    input  wire logic                          pwrite_in,
    input  wire logic [7:0]                    paddr_in,
    input  wire logic [31:0]                   pwdata_in,
    output logic [31:0]                        prdata_out,
    output logic                               pready_out,
    output logic                               pslverr_out,
    output logic                               adc_start_out,
    input  wire logic                          adc_done_in,
    input  wire logic [aiseq_pkg::SAMPLE_W-1:0] adc_data_in,
    input  wire logic                          ext_pace_in,
    input  wire logic                          start_trig_in,
    input  wire logic                          ref_trig_in,
    input  wire logic                          pause_trig_in,
    output logic                               blk_valid_out,
    output logic [aiseq_pkg::SAMPLE_W-1:0]     blk_data_out,
    input  wire logic                          blk_ready_in,
    output logic                               dma_req_out,
    output logic                               xfer_irq_out,
    output logic                               overflow_out
);
    import aiseq_pkg::*;

    // ========================================================
    // Reset release
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ========================================================
    // Registers and state
    logic [CTRL_W-1:0]   ctrl_q;
    logic [31:0]         count_q;
    logic [31:0]         done_cnt_q;
    logic [15:0]         div_q;
    logic [15:0]         div_cnt_q;
    logic [LEVEL_W-1:0]  block_q;
    logic                ovf_q;
    logic                done_q;
    logic                cfg_err_q;
    logic                busy_q;
    logic                ref_seen_q;
    logic                pace_d1_q;
    logic                strt_d1_q;
    logic                ref_d1_q;
    aiseq_state_type     state_q;
    logic [LEVEL_W-1:0]  level;
    logic                fifo_valid;
    logic                fifo_in_ready;
    logic [SAMPLE_W-1:0] fifo_data;

    // ========================================================
    // Bus decode: answer comes one cycle into the access phase
    wire access   = psel_in && penable_in && !pready_out;
    wire complete = psel_in && penable_in && pready_out;
    wire wr_ev    = complete && pwrite_in;
    wire rd_ev    = complete && !pwrite_in;
    wire hit_ctrl = (paddr_in == OFS_CTRL);
    wire hit_cmd  = (paddr_in == OFS_CMD);
    wire hit_stat = (paddr_in == OFS_STATUS);
    wire hit_cnt  = (paddr_in == OFS_COUNT);
    wire hit_done = (paddr_in == OFS_DONE_CNT);
    wire hit_data = (paddr_in == OFS_DATA);
    wire hit_div  = (paddr_in == OFS_DIVIDER);
    wire hit_blk  = (paddr_in == OFS_BLOCK);
    wire mapped   = hit_ctrl | hit_cmd | hit_stat | hit_cnt | hit_done
                  | hit_data | hit_div | hit_blk;
    wire cmd_wr   = wr_ev && hit_cmd;

    // Command decode
    wire cmd_convert = cmd_wr && pwdata_in[CMD_CONVERT];
    wire cmd_start   = cmd_wr && pwdata_in[CMD_START];
    wire cmd_stop    = cmd_wr && pwdata_in[CMD_STOP];
    wire cmd_clr_ovf = cmd_wr && pwdata_in[CMD_CLR_OVF];
    wire bad_cfg     = ctrl_q[CTRL_REF_EN] && ctrl_q[CTRL_CONTINUOUS];
    wire start_ok    = cmd_start && !bad_cfg && state_q == AISEQ_IDLE;
    wire buffered    = ctrl_q[CTRL_BUFFERED];

    // ========================================================
    // Pacing and trigger edges; internal pacing from the divider, the rest from digital inputs
    wire int_tick   = (div_cnt_q == div_q);
    wire ext_tick   = ext_pace_in && !pace_d1_q;
    wire pace_tick  = ctrl_q[CTRL_EXT_CLK] ? ext_tick : int_tick;
    wire start_edge = start_trig_in && !strt_d1_q;
    wire ref_edge   = ref_trig_in && !ref_d1_q;
    wire paused     = ctrl_q[CTRL_PAUSE_EN] && pause_trig_in;
    wire hw_conv    = state_q == AISEQ_RUN && ctrl_q[CTRL_HW_TIMED] && pace_tick
                    && !paused && !busy_q;
    wire sw_conv    = cmd_convert && !ctrl_q[CTRL_HW_TIMED] && !busy_q;
    wire conv_go    = hw_conv || sw_conv;

    // Finite count applies only after the reference event when enabled
    wire counting   = !ctrl_q[CTRL_REF_EN] || ref_seen_q;
    wire last_done  = adc_done_in && counting && !ctrl_q[CTRL_CONTINUOUS]
                    && state_q == AISEQ_RUN && (done_cnt_q + 32'h1 >= count_q);

    // Full FIFO on a new result: oldest sample is discarded
    wire smp_push   = adc_done_in;
    wire overwrite  = smp_push && !fifo_in_ready;
    wire take       = buffered ? blk_ready_in : (rd_ev && hit_data);
    wire out_load   = fifo_valid && (!blk_valid_out || take);
    wire fifo_pop   = out_load || overwrite;

    // ========================================================
    // Sample FIFO instance
    aiseq_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (mclk_in),
        .rstn_in       (rst_n_q),
        .in_valid_in   (smp_push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (adc_data_in),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_data),
        .level_out     (level)
    );

    // Read data selection
    wire [31:0] status_word = {16'h0000, 3'h0, level, 2'h0, busy_q, cfg_err_q,
                               done_q, ovf_q, state_q == AISEQ_WAIT_START,
                               state_q == AISEQ_RUN};
    wire [31:0] rd_mux =
          hit_ctrl ? {24'h000000, ctrl_q}
        : hit_stat ? status_word
        : hit_cnt  ? count_q
        : hit_done ? done_cnt_q
        : hit_data ? {16'h0000, blk_data_out}
        : hit_div  ? {16'h0000, div_q}
        : hit_blk  ? {27'h0000000, block_q}
        : 32'h0000_0000;

    // Block request when a whole block waits in the FIFO
    wire block_ready = buffered && state_q != AISEQ_IDLE && block_q != '0
                     && level >= block_q;

    // ========================================================
    // APB answer
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= access;
            pslverr_out <= access && !mapped;
            prdata_out  <= (access && !pwrite_in) ? rd_mux : 32'h0000_0000;
        end
    end

    // ========================================================
    // Configuration registers
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q  <= CTRL_RST;
            count_q <= COUNT_RST;
            div_q   <= DIVIDER_RST;
            block_q <= BLOCK_RST;
        end else if (wr_ev) begin
            if (hit_ctrl) ctrl_q <= pwdata_in[CTRL_W-1:0];
            if (hit_cnt) count_q <= pwdata_in;
            if (hit_div) div_q <= pwdata_in[15:0];
            if (hit_blk) block_q <= pwdata_in[LEVEL_W-1:0];
        end
    end

    // ========================================================
    // Acquisition sequence
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= AISEQ_IDLE;
        end else if (cmd_stop || last_done) begin
            state_q <= AISEQ_IDLE;
        end else if (start_ok) begin
            state_q <= ctrl_q[CTRL_START_EN] ? AISEQ_WAIT_START : AISEQ_RUN;
        end else if (state_q == AISEQ_WAIT_START && start_edge) begin
            state_q <= AISEQ_RUN;
        end
    end

    // Sample counting, reference latch and completion
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            done_cnt_q <= 32'h0000_0000;
            ref_seen_q <= 1'b0;
            done_q     <= 1'b0;
        end else if (start_ok) begin
            done_cnt_q <= 32'h0000_0000;
            ref_seen_q <= 1'b0;
            done_q     <= 1'b0;
        end else begin
            if (state_q == AISEQ_RUN && ctrl_q[CTRL_REF_EN] && ref_edge)
                ref_seen_q <= 1'b1;
            if (adc_done_in && counting && state_q == AISEQ_RUN)
                done_cnt_q <= done_cnt_q + 32'h1;
            if (last_done)
                done_q <= 1'b1;
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ovf_q     <= 1'b0;
            cfg_err_q <= 1'b0;
        end else begin
            if (overwrite) ovf_q <= 1'b1;
            else if (cmd_clr_ovf || start_ok) ovf_q <= 1'b0;
            if (cmd_start && bad_cfg) cfg_err_q <= 1'b1;
            else if (start_ok) cfg_err_q <= 1'b0;
        end
    end

    // Converter handshake and pacing divider
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            adc_start_out <= 1'b0;
            busy_q        <= 1'b0;
            div_cnt_q     <= 16'h0000;
            pace_d1_q     <= 1'b0;
            strt_d1_q     <= 1'b0;
            ref_d1_q      <= 1'b0;
        end else begin
            adc_start_out <= conv_go;
            busy_q        <= conv_go ? 1'b1 : (adc_done_in ? 1'b0 : busy_q);
            div_cnt_q     <= (int_tick || state_q != AISEQ_RUN) ? 16'h0000
                                                               : div_cnt_q + 16'h1;
            pace_d1_q     <= ext_pace_in;
            strt_d1_q     <= start_trig_in;
            ref_d1_q      <= ref_trig_in;
        end
    end

    // ========================================================
    // Output stage toward the block drain or direct host read
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            blk_valid_out <= 1'b0;
            blk_data_out  <= '0;
            dma_req_out   <= 1'b0;
            xfer_irq_out  <= 1'b0;
            overflow_out  <= 1'b0;
        end else begin
            if (out_load) begin
                blk_valid_out <= 1'b1;
                blk_data_out  <= fifo_data;
            end else if (take) begin
                blk_valid_out <= 1'b0;
            end
            dma_req_out  <= block_ready && !ctrl_q[CTRL_IRQ_XFER];
            xfer_irq_out <= block_ready && ctrl_q[CTRL_IRQ_XFER];
            overflow_out <= overwrite || (ovf_q && !cmd_clr_ovf && !start_ok);
        end
    end
endmodule

`default_nettype wire

// file: bench/aiseq_sva.sv
/*
 * Concurrent checks on the sequencer's ports: bus answer timing, converter
 * handshake, overflow flag life and block-drain stream stability.
 * Assumes the top module's ports only; bound at the foot of this file.
 */
`default_nettype none

// ========================================
// Port checker
module aiseq_sva (
    input wire logic                          mclk_in,
    input wire logic                          rstn_in,
    input wire logic                          psel_in,
    input wire logic                          penable_in,
    input wire logic                          pwrite_in,
    input wire logic [7:0]                    paddr_in,
    input wire logic [31:0]                   pwdata_in,
    input wire logic [31:0]                   prdata_out,
    input wire logic                          pready_out,
    input wire logic                          pslverr_out,
    input wire logic                          adc_start_out,
    input wire logic                          adc_done_in,
    input wire logic                          blk_valid_out,
    input wire logic [aiseq_pkg::SAMPLE_W-1:0] blk_data_out,
    input wire logic                          blk_ready_in,
    input wire logic                          dma_req_out,
    input wire logic                          xfer_irq_out,
    input wire logic                          overflow_out
);
    import aiseq_pkg::*;
    logic       pend_q;
    logic [2:0] done_hist_q;
    // Completing command write that may clear the overflow flag
    wire logic  clr_cmd = psel_in && penable_in && pready_out && pwrite_in
        && paddr_in == OFS_CMD && (pwdata_in[CMD_CLR_OVF] || pwdata_in[CMD_START]);

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    // Outstanding conversion and recent done history
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pend_q      <= 1'b0;
            done_hist_q <= 3'h0;
        end else begin
            pend_q      <= adc_start_out || (pend_q && !adc_done_in);
            done_hist_q <= {done_hist_q[1:0], adc_done_in};
        end
    end

    a_pready_timing: assert property ($rose(penable_in) && psel_in |=> pready_out)
        else $error("pready not one cycle after access start");
    a_pready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data nonzero outside answer");
    a_conv_single: assert property (adc_start_out |-> !pend_q)
        else $error("second conversion started before done");
    a_ovf_sticky: assert property (overflow_out && !clr_cmd |=> overflow_out)
        else $error("overflow dropped without clear");
    a_ovf_clear: assert property ($fell(overflow_out) |-> $past(clr_cmd))
        else $error("overflow fell without clear command");
    a_ovf_cause: assert property ($rose(overflow_out) |-> (|done_hist_q))
        else $error("overflow rose with no new sample");
    a_xfer_excl: assert property (!(dma_req_out && xfer_irq_out))
        else $error("dma and interrupt requests together");
    // A completing direct read of the data word pops the stage in non-buffered mode
    a_blk_hold: assert property (blk_valid_out && !blk_ready_in
        && !(psel_in && penable_in && pready_out && !pwrite_in && paddr_in == OFS_DATA)
        |=> blk_valid_out && $stable(blk_data_out))
        else $error("block word changed while stalled");
endmodule

bind aiseq_top aiseq_sva u_sva (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .adc_start_out(adc_start_out), .adc_done_in(adc_done_in),
    .blk_valid_out(blk_valid_out), .blk_data_out(blk_data_out), .blk_ready_in(blk_ready_in),
    .dma_req_out(dma_req_out), .xfer_irq_out(xfer_irq_out), .overflow_out(overflow_out));

`default_nettype wire

// file: bench/aiseq_far_model.sv
/*
 * Far-side model: a converter answering each start with one result after a
 * fixed delay, and a host drain that takes block words slowly or stalls.
 * Assumes the bench's clock and raw reset; results count up from a base.
 */
`default_nettype none

// ========================================
// Converter and drain model
module aiseq_far_model #(
    parameter int DLY = 6
) (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        start_in,
    output logic             done_out,
    output logic [15:0]      data_out,
    input  wire logic        stall_in,
    input  wire logic        valid_in,
    input  wire logic [15:0] word_in,
    output logic             ready_out,
    output logic [15:0]      cnv_out,
    output logic [15:0]      words_out,
    output logic [15:0]      last_out
);
    logic [7:0]  wait_q;
    logic [15:0] val_q;
    logic        alt_q;
    // Result only valid with done; otherwise the inverse shows
    assign data_out  = done_out ? val_q : ~val_q;
    assign ready_out = !stall_in && alt_q; // Half-rate drain, or stalled

    // One result per start, after DLY cycles
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wait_q   <= 8'h0;
            done_out <= 1'b0;
            val_q    <= 16'h0;
            cnv_out  <= 16'h0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                wait_q <= 8'(DLY);
            end else if (wait_q != 8'h0) begin
                wait_q <= wait_q - 8'h1;
                if (wait_q == 8'h1) begin
                    done_out <= 1'b1;
                    val_q    <= 16'ha000 + cnv_out;
                    cnv_out  <= cnv_out + 16'h1;
                end
            end
        end
    end

    // Host side takes block words
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            alt_q     <= 1'b0;
            words_out <= 16'h0;
            last_out  <= 16'h0;
        end else begin
            alt_q <= !alt_q;
            if (valid_in && ready_out) begin
                words_out <= words_out + 16'h1;
                last_out  <= word_in;
            end
        end
    end
endmodule

`default_nettype wire

// file: bench/test_aiseq_top.sv
/*
 * Bench for the sequencer: APB register tasks, on-demand and paced runs,
 * triggers, refusal of a bad mode and FIFO overflow with a stalled host.
 * Assumes the far-side model and the bound port checker.
 */
`default_nettype none

module test_aiseq_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aiseq_pkg::*;
    logic        mclk_in, rstn_in, psel, penable, pwrite, done, blk_v, blk_r, dma, irq, ovf;
    logic        start, ext_pace, st_trig, ref_trig, pause_trig, stall, rdy, err, err_v;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [15:0] adata, bdata, cnv, words, lastw, base, wbase;
    int          n_fail, cmp_count;

    aiseq_top dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(rdy), .pslverr_out(err), .adc_start_out(start), .adc_done_in(done),
        .adc_data_in(adata), .ext_pace_in(ext_pace), .start_trig_in(st_trig),
        .ref_trig_in(ref_trig), .pause_trig_in(pause_trig), .blk_valid_out(blk_v),
        .blk_data_out(bdata), .blk_ready_in(blk_r), .dma_req_out(dma),
        .xfer_irq_out(irq), .overflow_out(ovf));
    aiseq_far_model far (.clk_in(mclk_in), .rstn_in(rstn_in), .start_in(start),
        .done_out(done), .data_out(adata), .stall_in(stall), .valid_in(blk_v),
        .word_in(bdata), .ready_out(blk_r), .cnv_out(cnv), .words_out(words),
        .last_out(lastw));

    // ========================================
    // Tasks
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_in);
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; read data and error land in rd_v and err_v
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        // Wait for the answer as long as it takes; the watchdog ends a hang
        @(posedge mclk_in);
        while (rdy !== 1'b1) @(posedge mclk_in);
        rd_v = prdata;
        err_v = err;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_v, exp);
    endtask
    task automatic stbit(input int b, input logic exp, input string nm);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(nm, {31'h0, rd_v[b]}, {31'h0, exp});
    endtask
    task automatic run(input logic [7:0] ctrl);
        apb(1'b1, OFS_CTRL, {24'h0, ctrl});
        base = cnv;
        wbase = words;
        apb(1'b1, OFS_CMD, 32'h1 << CMD_START);
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ========================================
    // Clock and watchdog; reset is driven by the scenarios
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    initial begin
        cyc(30000);
        n_fail++;
        wrap_up();
    end

    // ========================================
    // Scenarios
    initial begin
        {rstn_in, psel, penable, pwrite, ext_pace, st_trig, ref_trig, pause_trig, stall} = '0;
        paddr = 8'h0; pwdata = 32'h0; n_fail = 0; cmp_count = 0;
        cyc(6);
        rstn_in <= 1'b1;
        cyc(3);
        rchk(OFS_CTRL, 32'h0, "ctrl reset");
        rchk(OFS_COUNT, 32'h1, "count reset");
        rchk(OFS_DIVIDER, 32'h27, "divider reset");
        rchk(OFS_BLOCK, 32'h8, "block reset");
        rchk(OFS_CMD, 32'h0, "cmd reads zero");
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", {31'h0, err_v}, 32'h1);
        // On-demand: one conversion per command, read singly
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFS_CMD, 32'h1 << CMD_CONVERT);
            cyc(20);
            chk("convert count", {16'h0, cnv}, i + 1);
            rchk(OFS_DATA, 32'ha000 + i, "direct read");
        end
        // Finite paced run on the internal clock, buffered drain
        apb(1'b1, OFS_DIVIDER, 32'h3);
        apb(1'b1, OFS_COUNT, 32'h5);
        run(8'h09);
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
        end while (rd_v[ST_DONE] !== 1'b1);
        cyc(30);
        chk("finite count", {16'h0, cnv - base}, 32'h5);
        chk("blocks drained", {16'h0, words - wbase}, 32'h5);
        chk("last word", {16'h0, lastw}, 32'ha006);
        rchk(OFS_DONE_CNT, 32'h5, "done count");
        // Continuous run paced by the external clock, past COUNT
        run(8'h0f);
        for (int i = 0; i < 10; i++) begin
            if (i == 8) apb(1'b1, OFS_CMD, 32'h1 << CMD_STOP);
            ext_pace <= 1'b1;
            cyc(6);
            ext_pace <= 1'b0;
            cyc(6);
        end
        cyc(20);
        chk("ext paced count", {16'h0, cnv - base}, 32'h8);
        // Pause trigger holds back conversions
        pause_trig <= 1'b1;
        run(8'h8d);
        cyc(60);
        chk("paused", {16'h0, cnv - base}, 32'h0);
        pause_trig <= 1'b0;
        cyc(60);
        chk("resumed", {31'h0, cnv != base}, 32'h1);
        stbit(ST_RUNNING, 1'b1, "continuous runs");
        apb(1'b1, OFS_CMD, 32'h1 << CMD_STOP);
        // Start then reference trigger, finite count of 2
        apb(1'b1, OFS_COUNT, 32'h2);
        run(8'h69);
        stbit(ST_ARMED, 1'b1, "armed");
        cyc(40);
        chk("no start yet", {16'h0, cnv - base}, 32'h0);
        st_trig <= 1'b1;
        cyc(60);
        st_trig <= 1'b0;
        stbit(ST_RUNNING, 1'b1, "wait reference");
        ref_trig <= 1'b1;
        cyc(80);
        ref_trig <= 1'b0;
        stbit(ST_RUNNING, 1'b0, "reference finish");
        rchk(OFS_DONE_CNT, 32'h2, "post trigger count");
        // Reference trigger with continuous mode is refused
        run(8'h45);
        stbit(ST_CFG_ERR, 1'b1, "mode refused");
        stbit(ST_RUNNING, 1'b0, "not running");
        // Stalled host: FIFO overflows, flag sticks until cleared
        cyc(20);
        stall <= 1'b1;
        run(8'h1d);
        while (ovf !== 1'b1) cyc(1);
        chk("irq transfer", {30'h0, irq, dma}, 32'h2);
        apb(1'b1, OFS_CMD, 32'h1 << CMD_STOP);
        cyc(30);
        chk("overflow sticky", {31'h0, ovf}, 32'h1);
        base = words;
        stall <= 1'b0;
        cyc(100);
        chk("kept words", {16'h0, words - base}, 32'd17);
        chk("newest kept", {16'h0, lastw}, 32'h9fff + cnv);
        apb(1'b1, OFS_CMD, 32'h1 << CMD_CLR_OVF);
        cyc(2);
        chk("overflow cleared", {31'h0, ovf}, 32'h0);
        wrap_up();
    end
endmodule

`default_nettype wire
